// *** aimx_adc_mux.v ***
// adc input mux control, deferred settings and result coding
`timescale 1ns/1ns
`include "aimx_defs.vh"

// Overview of operation
// - unipolar differential clamps to 0..0x3FF
// - bipolar result two's complement 0x200..0x1FF
// - bipolar result msb is sign
// - reset selects unipolar; bipolar bit enables
// - lowest channel bit selects 1x or 20x on differential codes
// - code 100010 routes and enables temp sensor
// - reference field decodes vcc, ext, internal, pin
// - reference change waits for conversion completion
// - channel change waits for conversion completion
// - code 11 drives internal reference onto pin
// - single-ended codes select inputs, ground, reference
// - code ranges for pairs, calibration, reversed
// - top channel bit swaps pair polarity
// - calibration codes tie inputs 0, 3, 7
// - differential codes map per pair table
// - control b bit 7 is bipolar mode
// - done flag sets; deferred settings apply one cycle later
module aimx_adc_mux
(
   input  wire        clock,
   input  wire        rst_b,
   input  wire        clk_en,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        conv_start,
   input  wire        conv_end,
   input  wire [10:0] conv_raw,
   output reg  [3:0]  afe_pos_sel,
   output reg  [3:0]  afe_neg_sel,
   output reg         afe_diff,
   output reg         afe_gain20,
   output reg  [1:0]  afe_ref_sel,
   output reg         afe_ref_to_pin,
   output reg         afe_temp_en,
   output reg         afe_bipolar,
   output reg  [9:0]  result_q,
   output reg         busy_q,
   output reg         done_q
);

   // ****************************************
   // channel decode
   // ****************************************
   // returns {diff, gain20, pos[3:0], neg[3:0]}
   function [9:0] chan_dec;
      input [5:0] c;
      reg   [3:0] p;
      reg   [3:0] n;
      reg         d;
      begin
         p = 4'h0;
         n = 4'h0;
         d = 1'b1;
         if (c[5:3] == 3'h0)
         begin
            p = {1'b0, c[2:0]};
            d = 1'b0;
         end
         else if (c == `AIMX_CH_ANALOG_GROUND_INPUT)
         begin
            p = `AIMX_SEL_ANALOG_GROUND_INPUT;
            d = 1'b0;
         end
         else if (c == `AIMX_CH_IREF)
         begin
            p = `AIMX_SEL_IREF;
            d = 1'b0;
         end
         else if (c == `AIMX_CH_TEMP)
         begin
            p = `AIMX_SEL_TEMP;
            d = 1'b0;
         end
         else if (c[5:3] == 3'h4)
         begin
            case (c[2:1])
               2'h1:    p = 4'h0;
               2'h2:    p = 4'h3;
               2'h3:    p = 4'h7;
               default: p = 4'h0;
            endcase
            n = p;
         end
         else
         begin
            case (c[4:1])
               4'h4:    begin p = 4'h0; n = 4'h1; end
               4'h5:    begin p = 4'h0; n = 4'h3; end
               4'h6:    begin p = 4'h1; n = 4'h2; end
               4'h7:    begin p = 4'h1; n = 4'h3; end
               4'h8:    begin p = 4'h2; n = 4'h3; end
               4'h9:    begin p = 4'h3; n = 4'h4; end
               4'hA:    begin p = 4'h3; n = 4'h5; end
               4'hB:    begin p = 4'h3; n = 4'h6; end
               4'hC:    begin p = 4'h3; n = 4'h7; end
               4'hD:    begin p = 4'h4; n = 4'h5; end
               4'hE:    begin p = 4'h5; n = 4'h6; end
               4'hF:    begin p = 4'h6; n = 4'h7; end
               default: begin p = 4'h0; n = 4'h0; end
            endcase
            if (c[5])
            begin
               {p, n} = {n, p};
            end
         end
         chan_dec = {d, d & c[0], p, n};
      end
   endfunction

   // ****************************************
   // registers and decode nets
   // ****************************************
   reg  [7:0]  mux_q;
   reg  [7:0]  csb_q;
   reg  [9:0]  coded_w;
   reg  [31:0] rd_w;
   reg  [1:0]  ref_w;
   reg         map_w;
   reg         hit_mux_w;
   reg         hit_csb_w;
   reg         hit_csa_w;
   reg         hit_res_w;
   reg         setup_w;
   reg         rd_setup_w;
   reg         commit_w;
   reg         fin_w;
   reg         idle_w;
   wire [9:0]  dec_w = chan_dec(mux_q[5:0]);
   wire        acc_w = psel & penable & clk_en;
   wire        wr_w  = acc_w & pwrite;

   // ****************************************
   // register address decode
   // ****************************************
   // high when a bus address names one register word
   function reg_hit;
      input [11:0] a;
      input [11:0] ofs;
      begin
         reg_hit = (a == ofs);
      end
   endfunction

   always @*
   begin
      hit_mux_w = reg_hit(paddr, `AIMX_OFS_MUX);
      hit_csb_w = reg_hit(paddr, `AIMX_OFS_CSB);
      hit_csa_w = reg_hit(paddr, `AIMX_OFS_CSA);
      hit_res_w = reg_hit(paddr, `AIMX_OFS_RES);
      map_w     = hit_mux_w | hit_csb_w | hit_csa_w | hit_res_w;
      ref_w     = mux_q[`AIMX_REF_HI:`AIMX_REF_LO];
   end

   // ****************************************
   // transfer and conversion qualifiers
   // ****************************************
   always @*
   begin
      setup_w    = psel & ~penable;
      rd_setup_w = psel & ~penable & ~pwrite;
      commit_w   = wr_w & pready;
      fin_w      = conv_end & busy_q;
      idle_w     = ~busy_q & ~conv_start;
   end

   // ****************************************
   // read data select
   // ****************************************
   always @*
   begin
      rd_w = 32'h0000_0000;
      if (hit_mux_w)
         rd_w = {24'h0, mux_q};
      else if (hit_csb_w)
         rd_w = {24'h0, csb_q};
      else if (hit_csa_w)
         rd_w = {24'h0, 1'b0, busy_q, 1'b0, done_q, 4'h0};
      else if (hit_res_w)
         rd_w = {22'h0, result_q};
   end

   // ****************************************
   // result coding
   // ****************************************
   always @*
   begin
      if (!afe_diff || !afe_bipolar)
      begin
         if (conv_raw[10])
            coded_w = 10'h000;
         else if (conv_raw[9:0] > `AIMX_UNI_MAX)
            coded_w = `AIMX_UNI_MAX;
         else
            coded_w = conv_raw[9:0];
      end
      else if (conv_raw[10] && conv_raw[9:0] < `AIMX_BIP_MIN)
         coded_w = `AIMX_BIP_MIN;
      else if (!conv_raw[10] && conv_raw[9:0] > `AIMX_BIP_MAX)
         coded_w = `AIMX_BIP_MAX;
      else
         coded_w = {conv_raw[10], conv_raw[8:0]};
   end

   // ****************************************
   // apb slave
   // ****************************************
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (clk_en)
      begin
         pready  <= setup_w;
         pslverr <= setup_w & ~map_w;
         if (rd_setup_w)
            prdata <= rd_w;
         else
            prdata <= 32'h0000_0000;
      end
   end

   // ****************************************
   // settings registers
   // ****************************************
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mux_q <= `AIMX_MUX_RESET;
         csb_q <= `AIMX_CSB_RESET;
      end
      else if (clk_en)
      begin
         if (commit_w && hit_mux_w)
            mux_q <= pwdata[7:0];
         if (commit_w && hit_csb_w)
            csb_q <= pwdata[7:0];
      end
   end

   // ****************************************
   // conversion state
   // ****************************************
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         busy_q <= 1'b0;
      else if (clk_en)
      begin
         if (conv_start && !busy_q)
            busy_q <= 1'b1;
         else if (conv_end)
            busy_q <= 1'b0;
      end
   end

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         done_q <= 1'b0;
      else if (clk_en)
      begin
         // done clear by writing one; completion wins
         if (fin_w)
            done_q <= 1'b1;
         else if (commit_w && hit_csa_w && pwdata[`AIMX_DONE_BIT])
            done_q <= 1'b0;
      end
   end

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         result_q <= 10'h000;
      else if (clk_en && fin_w)
         result_q <= coded_w;
   end

   // ****************************************
   // front end channel controls
   // ****************************************
   // front end follows settings only while idle
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         afe_pos_sel <= 4'h0;
         afe_neg_sel <= 4'h0;
         afe_diff    <= 1'b0;
         afe_gain20  <= 1'b0;
         afe_temp_en <= 1'b0;
      end
      else if (clk_en && idle_w)
      begin
         afe_diff    <= dec_w[9];
         afe_gain20  <= dec_w[8];
         afe_pos_sel <= dec_w[7:4];
         afe_neg_sel <= dec_w[3:0];
         afe_temp_en <= (mux_q[5:0] == `AIMX_CH_TEMP);
      end
   end

   // ****************************************
   // front end reference and mode controls
   // ****************************************
   // reference codes: 0 vcc, 1 ext pin, 2 internal, 3 internal to pin
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         afe_ref_sel    <= `AIMX_REF_VCC;
         afe_ref_to_pin <= 1'b0;
         afe_bipolar    <= 1'b0;
      end
      else if (clk_en && idle_w)
      begin
         afe_ref_sel    <= ref_w;
         afe_ref_to_pin <= (ref_w == `AIMX_REF_PIN);
         afe_bipolar    <= csb_q[`AIMX_BIN_BIT];
      end
   end

endmodule // aimx_adc_mux

// *** aimx_defs.vh ***
// register offsets, field positions, reset values and codes for the adc mux
`ifndef AIMX_DEFS_VH
`define AIMX_DEFS_VH
`define AIMX_OFS_CSA       12'h018
`define AIMX_OFS_CSB       12'h00C
`define AIMX_OFS_MUX       12'h01C
`define AIMX_OFS_RES       12'h010
`define AIMX_MUX_RESET     8'h00
`define AIMX_CSB_RESET     8'h00
`define AIMX_REF_HI        7
`define AIMX_REF_LO        6
`define AIMX_BIN_BIT       7
`define AIMX_DONE_BIT      4
`define AIMX_BUSY_BIT      6
`define AIMX_CH_ANALOG_GROUND_INPUT       6'h20
`define AIMX_CH_IREF       6'h21
`define AIMX_CH_TEMP       6'h22
`define AIMX_REF_VCC       2'h0
`define AIMX_REF_EXT       2'h1
`define AIMX_REF_INT       2'h2
`define AIMX_REF_PIN       2'h3
`define AIMX_SEL_ANALOG_GROUND_INPUT      4'h8
`define AIMX_SEL_IREF      4'h9
`define AIMX_SEL_TEMP      4'hA
`define AIMX_UNI_MAX       10'h3FF
`define AIMX_BIP_MIN       10'h200
`define AIMX_BIP_MAX       10'h1FF
`endif

// *** aimx_adc_mux_props.sv ***
// assertions on the adc mux control ports
`timescale 1ns/1ns
module aimx_adc_mux_props
(
   input logic        clock,
   input logic        rst_b,
   input logic        clk_en,
   input logic        psel,
   input logic        penable,
   input logic        pready,
   input logic        conv_start,
   input logic        conv_end,
   input logic [10:0] conv_raw,
   input logic [3:0]  afe_pos_sel,
   input logic [1:0]  afe_ref_sel,
   input logic        afe_diff,
   input logic        afe_ref_to_pin,
   input logic        afe_bipolar,
   input logic [9:0]  result_q,
   input logic        busy_q,
   input logic        done_q
);
   // ****
   // properties
   // ****
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   sequence fin_s;
      conv_end && busy_q && clk_en;
   endsequence
   ready_after_setup_a:
      assert property (psel && !penable && clk_en |=> pready)
      else $error("ready missing");
   ref_pin_a:
      assert property (afe_ref_to_pin == (afe_ref_sel == 2'h3))
      else $error("ref pin wrong");
   busy_on_start_a:
      assert property (conv_start && !busy_q && clk_en |=> busy_q)
      else $error("busy missing");
   done_on_end_a:
      assert property (fin_s |=> done_q && !busy_q)
      else $error("done missing");
   setting_hold_a:
      assert property (busy_q ##1 busy_q |->
         $stable(afe_ref_sel) && $stable(afe_pos_sel))
      else $error("setting moved while busy");
   uni_floor_a:
      assert property (fin_s ##0 ((!afe_bipolar || !afe_diff) && conv_raw[10])
         |=> result_q == 10'h000)
      else $error("unipolar floor wrong");
   bip_sign_a:
      assert property (fin_s ##0 (afe_bipolar && afe_diff)
         |=> result_q[9] == $past(conv_raw[10]))
      else $error("sign wrong");
   bip_top_a:
      assert property (fin_s ##0 (afe_bipolar && afe_diff &&
         conv_raw[10:9] == 2'h1)
         |=> result_q == 10'h1FF)
      else $error("bipolar top wrong");
endmodule // aimx_adc_mux_props
bind aimx_adc_mux aimx_adc_mux_props props_i (.clock, .rst_b, .clk_en, .psel,
   .penable, .pready, .conv_start, .conv_end, .conv_raw, .afe_pos_sel,
   .afe_ref_sel, .afe_diff, .afe_ref_to_pin, .afe_bipolar, .result_q, .busy_q,
   .done_q);

// *** aimx_adc_mux_tb_top.sv ***
// self-checking bench for the adc mux control block
`timescale 1ns/1ns
module aimx_adc_mux_tb_top;
   // ****
   // signals and tasks
   // ****
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        conv_start = 1'b0;
   logic        conv_end = 1'b0;
   logic [10:0] conv_raw = 11'h000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, er, afe_diff, afe_gain20, afe_ref_to_pin;
   logic [3:0]  afe_pos_sel, afe_neg_sel;
   logic [1:0]  afe_ref_sel;
   logic        afe_temp_en, afe_bipolar, busy_q, done_q;
   logic [9:0]  result_q;
   logic [16:0] rows [9];
   logic [21:0] cres [4];
   logic [10:0] ex;
   int          err_total = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   int          i;
   aimx_adc_mux dut (.clock, .rst_b, .clk_en(1'b1), .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .conv_start, .conv_end,
      .conv_raw, .afe_pos_sel, .afe_neg_sel, .afe_diff, .afe_gain20,
      .afe_ref_sel, .afe_ref_to_pin, .afe_temp_en, .afe_bipolar, .result_q,
      .busy_q, .done_q);
   always #10 clock = ~clock;
   task print_verdict;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_total++;
         print_verdict;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
         @(posedge clock);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task conv(input logic [10:0] raw, input logic mid);
      @(posedge clock);
      conv_start <= 1'b1;
      @(posedge clock);
      conv_start <= 1'b0;
      if (mid)
         apb(1'b1, 12'h01C, 32'h6A);
      @(posedge clock);
      conv_end <= 1'b1;
      conv_raw <= raw;
      @(posedge clock);
      conv_end <= 1'b0;
      #1;
   endtask
   // ****
   // main sequence
   // ****
   initial
   begin
      rows = '{{6'h00, 11'h000}, {6'h20, 11'h400}, {6'h22, 11'h501},
         {6'h08, 11'h00C}, {6'h09, 11'h00E}, {6'h28, 11'h084},
         {6'h3F, 11'h3B6}, {6'h23, 11'h006}, {6'h24, 11'h19C}};
      cres = '{{1'b0, 11'h7FF, 10'h000}, {1'b0, 11'h3FF, 10'h3FF},
         {1'b1, 11'h600, 10'h200}, {1'b1, 11'h3FF, 10'h1FF}};
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      #1;
      chk(afe_bipolar, 1'b0);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 12'h004, 32'hFF);
      chk({er, 4'h0}, 5'h10);
      for (i = 0; i < 4; i++)
      begin
         apb(1'b1, 12'h01C, 32'(i * 64));
         repeat (2) @(posedge clock);
         #1;
         chk({afe_ref_sel, afe_ref_to_pin}, 3'(i * 2 + (i == 3)));
      end
      for (i = 0; i < 9; i++)
      begin
         apb(1'b1, 12'h01C, {24'h0, 2'h2, rows[i][16:11]});
         repeat (2) @(posedge clock);
         #1;
         ex = {afe_pos_sel, afe_neg_sel, afe_diff, afe_gain20, afe_temp_en};
         ex[1] = ex[1] & ex[2];
         chk(ex, rows[i][10:0]);
      end
      for (i = 0; i < 4; i++)
      begin
         apb(1'b1, 12'h00C, {24'h0, cres[i][21], 7'h00});
         conv(cres[i][20:10], 1'b0);
         chk(result_q, cres[i][9:0]);
         apb(1'b0, 12'h010, 32'h0);
         chk(rd, cres[i][9:0]);
      end
      apb(1'b1, 12'h018, 32'h10);
      apb(1'b0, 12'h018, 32'h0);
      chk(rd[4], 1'b0);
      apb(1'b1, 12'h01C, 32'h08);
      repeat (25) @(posedge clock);
      conv(11'h001, 1'b1);
      chk({afe_ref_sel, afe_pos_sel}, 6'h00);
      chk(done_q, 1'b1);
      repeat (2) @(posedge clock);
      #1;
      chk({afe_ref_sel, afe_pos_sel}, 6'h13);
      rst_b <= 1'b0;
      #1;
      chk({done_q, result_q}, 11'h000);
      print_verdict;
   end
endmodule // aimx_adc_mux_tb_top
